// [core/sgc_pkg.sv]
package sgc_pkg;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int CEASE_TIME_US  = 260;
    localparam int OFF_TIME_US    = 21;
    localparam int BLANK_TIME_NS  = 240;
    localparam int WINDOW_TIME_NS = 166;
    localparam int SLEEP_HALF_NS  = 1100;
    // least times round up, longest times round down
    localparam int CEASE_CYC  = CEASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int OFF_CYC    = OFF_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int BLANK_CYC  = (BLANK_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int WINDOW_CYC = WINDOW_TIME_NS / CLK_PERIOD_NS;
    localparam int SLEEP_PER_CYC = 2 * SLEEP_HALF_NS / CLK_PERIOD_NS;
    localparam int SLEEP_PULSES  = 5;
    localparam int BURST_PULSES  = 16;
    // counter widths
    localparam int CEASE_W = 12;
    localparam int OFF_W   = 8;
    localparam int IVL_W   = 6;
    localparam int ON_W    = 4;
    localparam int CNT_W   = 5;
    // synchroniser lane order and reset levels
    localparam int SYN_W = 7;
    localparam logic [SYN_W-1:0] SYN_RST = 7'h01; // command input idles high

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ON   = 3'b010,
        ST_OFFT = 3'b100
    } sgc_state_t;
endpackage

// [core/sgc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sgc_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic         clk,  // system clock
    input  wire logic         nrst, // async reset, active low
    input  wire logic         en,   // clock enable
    input  wire logic [W-1:0] d,    // asynchronous inputs
    output logic      [W-1:0] q     // filtered synchronous copies
);
    logic [W-1:0] f1_q;
    logic [W-1:0] f2_q;
    logic [W-1:0] f3_q;

    genvar i;
    // three stages per lane, output moves when stages two and three agree
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    f1_q[i] <= RST[i];
                    f2_q[i] <= RST[i];
                    f3_q[i] <= RST[i];
                    q[i]    <= RST[i];
                end
                else if (en)
                begin
                    f1_q[i] <= d[i];
                    f2_q[i] <= f1_q[i];
                    f3_q[i] <= f2_q[i];
                    if (f2_q[i] == f3_q[i])
                        q[i] <= f3_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [core/sgc_gate_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module sgc_gate_ctrl (
    input  wire logic clk,            // 10 MHz timebase
    input  wire logic nrst,           // async reset, active low
    input  wire logic en,             // clock enable, freezes all state
    input  wire logic cmd_n,          // command pin, active low
    input  wire logic peak_cmp,       // peak_limit_comparator output
    input  wire logic window_cmp,     // ccm_window_comparator output
    input  wire logic undervoltage_lockout,           // undervoltage_lockout active
    input  wire logic overvoltage_lockout,           // overvoltage_lockout active
    input  wire logic reg_off,        // linear regulator switched off
    input  wire logic osc_in,         // slow_burst_oscillator square wave
    output logic      gate,           // gate driver command
    output logic      ext_mode,       // external commands own the gate
    output logic      sleep,          // sleep state
    output logic      peak_ref_high,  // select high peak_limit_reference
    output logic      blanking,       // leading_edge_blanking active
    output logic      window_open     // window comparator interval
);
    import sgc_pkg::*;

    logic [SYN_W-1:0]   syn;
    logic               s_cmd_n, s_peak, s_win, s_uv, s_ov, s_regoff, s_osc;
    logic               cmd_prev_q, osc_prev_q;
    logic               cmd_fall, cmd_edge, osc_rise;
    logic [CEASE_W-1:0] cease_q;
    logic               active_q;
    logic [IVL_W-1:0]   ivl_q;
    logic               short_ivl;
    logic [2:0]         burst_q;
    logic               sleep_q;
    logic               ext_on_q;
    logic               gate_q;
    logic [ON_W-1:0]    on_cnt_q;
    logic               blank, window, trip, inhibit, int_ok;
    sgc_state_t         st_q;
    logic [OFF_W-1:0]   off_q;
    logic               off_done;
    logic               lfo_on_q;
    logic [CNT_W-1:0]   lfo_cnt_q;

    // all outside flags enter through the filtered synchroniser
    sgc_sync #(.W(SYN_W), .RST(SYN_RST)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .en   (en),
        .d    ({osc_in, reg_off, overvoltage_lockout, undervoltage_lockout, window_cmp, peak_cmp, cmd_n}),
        .q    (syn)
    );
    assign {s_osc, s_regoff, s_ov, s_uv, s_win, s_peak, s_cmd_n} = syn;

    // edge detection on command and oscillator
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_prev_q <= 1'b1;
            osc_prev_q <= 1'b0;
        end
        else if (en)
        begin
            cmd_prev_q <= s_cmd_n;
            osc_prev_q <= s_osc;
        end
    end
    assign cmd_fall = cmd_prev_q && !s_cmd_n;
    assign cmd_edge = cmd_prev_q != s_cmd_n;
    assign osc_rise = s_osc && !osc_prev_q;

    // activity timeout: any command edge restarts it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cease_q  <= '0;
            active_q <= 1'b0;
        end
        else if (en)
        begin
            if (cmd_edge)
            begin
                cease_q  <= '0;
                active_q <= 1'b1;
            end
            else if (active_q)
            begin
                if (cease_q == CEASE_W'(CEASE_CYC - 1))
                    active_q <= 1'b0;
                else
                    cease_q <= cease_q + 1'b1;
            end
        end
    end

    // period between falling edges, saturating
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ivl_q <= '1;
        else if (en)
        begin
            if (cmd_fall)
                ivl_q <= '0;
            else if (ivl_q != '1)
                ivl_q <= ivl_q + 1'b1;
        end
    end
    assign short_ivl = ivl_q < IVL_W'(SLEEP_PER_CYC);

    // burst detection and sleep, undervoltage wins over entry
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            burst_q <= '0;
            sleep_q <= 1'b0;
        end
        else if (en)
        begin
            if (s_uv)
            begin
                burst_q <= '0;
                sleep_q <= 1'b0;
            end
            else if (cmd_fall)
            begin
                if (!short_ivl)
                begin
                    burst_q <= 3'h1;
                    sleep_q <= 1'b0;
                end
                else if (burst_q == 3'(SLEEP_PULSES - 1))
                begin
                    burst_q <= '0;
                    sleep_q <= 1'b1;
                end
                else
                    burst_q <= burst_q + 1'b1;
            end
        end
    end

    // mode selection and gating permission
    assign ext_mode = active_q && s_regoff;
    assign int_ok   = !s_uv && !ext_mode;
    assign inhibit  = s_uv || s_ov || sleep_q;
    assign peak_ref_high = ext_mode;

    // blanking then window timing from each on-time start
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            on_cnt_q <= '0;
        else if (en)
        begin
            if (!gate_q)
                on_cnt_q <= '0;
            else if (on_cnt_q != '1)
                on_cnt_q <= on_cnt_q + 1'b1;
        end
    end
    assign blank  = gate_q && on_cnt_q < ON_W'(BLANK_CYC);
    assign window = gate_q && !blank
                    && on_cnt_q < ON_W'(BLANK_CYC + WINDOW_CYC);
    assign trip   = gate_q && !blank
                    && (s_peak || (window && s_win));
    assign blanking    = blank;
    assign window_open = window;

    // burst oscillator: on-portion of 16 regulator periods
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lfo_on_q  <= 1'b0;
            lfo_cnt_q <= '0;
        end
        else if (en)
        begin
            if (ext_mode)
            begin
                lfo_on_q  <= 1'b0;
                lfo_cnt_q <= '0;
            end
            else if (osc_rise)
            begin
                lfo_on_q  <= 1'b1;
                lfo_cnt_q <= '0;
            end
            else if (off_done && lfo_on_q)
            begin
                lfo_cnt_q <= lfo_cnt_q + 1'b1;
                if (lfo_cnt_q == CNT_W'(BURST_PULSES - 1))
                    lfo_on_q <= 1'b0;
            end
        end
    end

    // internal peak current regulator
    assign off_done = st_q == ST_OFFT && off_q == OFF_W'(OFF_CYC - 1);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q  <= ST_IDLE;
            off_q <= '0;
        end
        else if (en)
        begin
            unique case (st_q)
                ST_IDLE:
                    if (int_ok && !inhibit && lfo_on_q)
                        st_q <= ST_ON;
                ST_ON:
                    if (!int_ok || inhibit)
                        st_q <= ST_IDLE;
                    else if (trip)
                    begin
                        st_q  <= ST_OFFT;
                        off_q <= '0;
                    end
                ST_OFFT:
                    if (off_done)
                        st_q <= ST_IDLE;
                    else
                        off_q <= off_q + 1'b1;
            endcase
        end
    end

    // external latch: low command turns on, trip ends until next on
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ext_on_q <= 1'b0;
        else if (en)
        begin
            if (cmd_fall)
                ext_on_q <= 1'b1;
            else if (s_cmd_n || trip)
                ext_on_q <= 1'b0;
        end
    end

    // gate register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            gate_q <= 1'b0;
        else if (en)
        begin
            if (inhibit)
                gate_q <= 1'b0;
            else if (ext_mode)
                gate_q <= (ext_on_q || cmd_fall) && !trip;
            else
                gate_q <= st_q == ST_ON && !trip && int_ok;
        end
    end
    assign gate  = gate_q;
    assign sleep = sleep_q;

    a_uv_gate_off: assert property (@(posedge clk) disable iff (!nrst)
        en && s_uv |=> !gate_q) else $error("gate on under undervoltage");
    a_ov_gate_off: assert property (@(posedge clk) disable iff (!nrst)
        en && s_ov |=> !gate_q) else $error("gate on under overvoltage");
    a_sleep_gate: assert property (@(posedge clk) disable iff (!nrst)
        en && sleep_q |=> !gate_q) else $error("gate on in sleep");
    a_wake_uv: assert property (@(posedge clk) disable iff (!nrst)
        en && s_uv |=> !sleep_q) else $error("sleep kept under undervoltage_lockout");
    a_burst_sleep: assert property (@(posedge clk) disable iff (!nrst)
        en && !s_uv && cmd_fall && short_ivl && burst_q == 3'h4
        |=> sleep_q) else $error("burst missed");
    a_blank_mask: assert property (@(posedge clk) disable iff (!nrst)
        $rose(gate_q) && en |-> !trip ##1 !trip ##1 !trip)
        else $error("trip inside blanking");
    a_off_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st_q == ST_OFFT) |-> (st_q == ST_OFFT && !gate_q) [*8])
        else $error("off time cut short");
    a_cease_rel: assert property (@(posedge clk) disable iff (!nrst)
        en && active_q && !cmd_edge && cease_q == CEASE_W'(CEASE_CYC - 1)
        |=> !active_q) else $error("timeout not taken");
    a_lfo_stop: assert property (@(posedge clk) disable iff (!nrst)
        en && !ext_mode && !osc_rise && off_done && lfo_on_q
        && lfo_cnt_q == CNT_W'(BURST_PULSES - 1) |=> !lfo_on_q)
        else $error("burst on-portion not ended");
    a_ext_follow: assert property (@(posedge clk) disable iff (!nrst)
        en && ext_mode && !inhibit && cmd_fall && !trip |=> gate_q)
        else $error("on command ignored");
    a_ext_trip: assert property (@(posedge clk) disable iff (!nrst)
        en && ext_mode && trip && !cmd_fall |=> (!gate_q && !ext_on_q))
        else $error("trip did not end on-time");
endmodule
`default_nettype wire

// [dv/sgc_sec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sgc_sec_model (
    input  wire logic clk,   // timebase shared with the block
    output logic      cmd_n  // isolated command line, active low
);
    // line starts at the released level, driven high
    initial cmd_n = 1'b1;

    // hold the line at one level for a number of cycles
    task automatic level(input logic v, input int cyc);
        cmd_n = v;
        repeat (cyc) @(negedge clk);
    endtask

    // one regulated period of 200 cycles, 50 kHz
    task automatic pwm(input int low_cyc);
        level(1'b0, low_cyc);
        level(1'b1, 200 - low_cyc);
    endtask

    // five fast pulses at 500 kHz ask for sleep
    task automatic burst();
        repeat (5)
        begin
            level(1'b0, 10);
            level(1'b1, 10);
        end
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sgc_pkg::*;
    logic clk, nrst, en, peak_cmp, window_cmp, undervoltage_lockout, overvoltage_lockout, reg_off, osc_in;
    logic cmd_n, gate, ext_mode, sleep, peak_ref_high, blanking, window_open;
    int   fail_count = 0;
    int   checks_done = 0;

    // 10 MHz timebase
    initial clk = 1'b0;
    always #50 clk = ~clk;

    sgc_sec_model u_sgc_sec_model (.clk(clk), .cmd_n(cmd_n));
    sgc_gate_ctrl u_sgc_gate_ctrl (
        .clk(clk), .nrst(nrst), .en(en), .cmd_n(cmd_n),
        .peak_cmp(peak_cmp), .window_cmp(window_cmp), .undervoltage_lockout(undervoltage_lockout),
        .overvoltage_lockout(overvoltage_lockout), .reg_off(reg_off), .osc_in(osc_in), .gate(gate),
        .ext_mode(ext_mode), .sleep(sleep), .peak_ref_high(peak_ref_high),
        .blanking(blanking), .window_open(window_open)
    );

    // compare one output bit and count the result
    task automatic check(input logic seen, input logic exp, input string m);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask

    // step some cycles and count gate turn-ons
    task automatic run(input int cyc, output int rises);
        logic prev;
        prev = gate;
        rises = 0;
        repeat (cyc)
        begin
            @(negedge clk);
            if (gate === 1'b1 && prev === 1'b0)
                rises++;
            prev = gate;
        end
    endtask

    // lockout flags keep the internal regulator off until released
    task automatic t_lock(input logic ov);
        int n;
        peak_cmp = 1'b1;
        overvoltage_lockout = ov;
        undervoltage_lockout = !ov;
        osc_in = 1'b1;
        repeat (10) @(negedge clk);
        osc_in = 1'b0;
        run(800, n);
        check(n == 0, 1'b1, "gate under lockout");
        undervoltage_lockout = 1'b0;
        overvoltage_lockout = 1'b0;
        run(300, n);
        check(n > 0, 1'b1, "no gate after release");
        run(4000, n);
        $display("done lockout %0d", ov);
    endtask

    // sixteen blanked, tripped pulses per oscillator period
    task automatic t_count();
        int   rises = 0;
        int   hi = 0;
        int   hi_max = 0;
        int   lo = 0;
        int   lo_min = 9999;
        logic prev = 1'b0;
        peak_cmp = 1'b1;
        osc_in = 1'b1;
        for (int i = 0; i < 4500; i++)
        begin
            @(negedge clk);
            if (i == 10)
                osc_in = 1'b0;
            if (gate === 1'b1 && prev === 1'b0)
            begin
                rises++;
                check(blanking, 1'b1, "no blanking at turn-on");
                check(window_open, 1'b0, "window inside blanking");
                if (rises > 1 && lo < lo_min)
                    lo_min = lo;
            end
            hi = gate ? hi + 1 : 0;
            lo = gate ? 0 : lo + 1;
            hi_max = hi > hi_max ? hi : hi_max;
            prev = gate;
        end
        peak_cmp = 1'b0;
        check(rises == 16, 1'b1, "pulse count");
        check(hi_max <= BLANK_CYC + 3, 1'b1, "on-time not ended");
        check(lo_min inside {[OFF_CYC - 1:OFF_CYC + 8]}, 1'b1, "toff");
        $display("done count");
    endtask

    // regulated commands own the gate once the regulator is off
    task automatic t_ext();
        reg_off = 1'b0;
        repeat (2)
        begin
            u_sgc_sec_model.level(1'b0, 30);
            check(gate, 1'b0, "command with regulator on");
            u_sgc_sec_model.level(1'b1, 170);
        end
        reg_off = 1'b1;
        repeat (3) u_sgc_sec_model.pwm(60);
        osc_in = 1'b1;
        repeat (4)
        begin
            u_sgc_sec_model.level(1'b0, 30);
            osc_in = 1'b0;
            check(gate, 1'b1, "gate on command low");
            check(ext_mode, 1'b1, "external mode");
            check(peak_ref_high, 1'b1, "high peak reference");
            u_sgc_sec_model.level(1'b0, 30);
            u_sgc_sec_model.level(1'b1, 70);
            check(gate, 1'b0, "gate on command high");
            u_sgc_sec_model.level(1'b1, 70);
        end
        $display("done external");
    endtask

    // comparator trips end the on-time until the next command
    task automatic t_trip();
        u_sgc_sec_model.level(1'b0, 20);
        peak_cmp = 1'b1;
        u_sgc_sec_model.level(1'b0, 10);
        peak_cmp = 1'b0;
        u_sgc_sec_model.level(1'b0, 30);
        check(gate, 1'b0, "peak trip");
        window_cmp = 1'b1;
        u_sgc_sec_model.level(1'b1, 140);
        u_sgc_sec_model.level(1'b0, 30);
        check(gate, 1'b0, "window trip");
        window_cmp = 1'b0;
        u_sgc_sec_model.level(1'b1, 170);
        u_sgc_sec_model.level(1'b0, 20);
        window_cmp = 1'b1;
        u_sgc_sec_model.level(1'b0, 20);
        check(gate, 1'b1, "trip outside window");
        window_cmp = 1'b0;
        u_sgc_sec_model.level(1'b1, 160);
        u_sgc_sec_model.level(1'b0, 60);
        u_sgc_sec_model.level(1'b1, 2500);
        check(ext_mode, 1'b1, "early fallback");
        u_sgc_sec_model.level(1'b1, 200);
        check(ext_mode, 1'b0, "no fallback");
        $display("done trip and cease");
    endtask

    // a fast burst puts the block to sleep; commands or undervoltage wake it
    task automatic t_sleep();
        repeat (3) u_sgc_sec_model.pwm(60);
        for (int k = 0; k < 2; k++)
        begin
            u_sgc_sec_model.burst();
            u_sgc_sec_model.level(1'b1, 50);
            check(sleep, 1'b1, "no sleep");
            check(gate, 1'b0, "gate in sleep");
            undervoltage_lockout = (k == 1);
            u_sgc_sec_model.level(logic'(k == 1), 30);
            check(sleep, 1'b0, "no wake");
            undervoltage_lockout = 1'b0;
            u_sgc_sec_model.level(1'b1, 140);
        end
        $display("done sleep");
    endtask

    // closing report and verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog at roughly three times the expected run
    initial
    begin
        #6_000_000;
        fail_count++;
        tally_and_finish();
    end

    // reset, then the scenarios in order
    initial
    begin
        nrst = 1'b0;
        en = 1'b1;
        {peak_cmp, window_cmp, undervoltage_lockout, overvoltage_lockout, reg_off, osc_in} = 6'h00;
        repeat (12) @(negedge clk);
        check(gate, 1'b0, "gate in reset");
        check(sleep, 1'b0, "sleep in reset");
        check(ext_mode, 1'b0, "mode in reset");
        nrst = 1'b1;
        t_lock(1'b0);
        t_lock(1'b1);
        t_count();
        t_ext();
        t_trip();
        t_sleep();
        tally_and_finish();
    end
endmodule
`default_nettype wire
